// ---- src/hdlctx_regs.vh ----
// Constants for the D-channel HDLC transmitter: register map, fields, timing.
// Assumes an 8-bit register port and a 200 MHz system clock.
//
// What this block does
// RULE_01 - Transmit FIFO is two 32-byte pools, drained alternately.
// RULE_02 - Software writes up to 32 bytes only into a ready pool.
// RULE_03 - Transparent frames are loaded whole, header octets included.
// RULE_04 - Info frames only in auto mode; block prepends header.
// RULE_05 - Two-byte address: first register high octet, second low.
// RULE_06 - Two-byte address: bit 1 of high octet marks command/response.
// RULE_07 - One-byte address: register choice marks command or response.
// RULE_08 - Control field from internal send and receive counters.
// RULE_09 - Auto mode sends supervisory frames; unnumbered go transparent.
// RULE_10 - Pool-ready each time the FIFO holds at most 32 bytes.
// RULE_11 - Software refills and reissues the command to continue.
// RULE_12 - Message end: block appends CRC and closing flag.
// RULE_13 - FIFO empty mid-frame: seven ones, underrun event.
// RULE_14 - Transmitter reset aborts the message, raises pool-ready.
// RULE_15 - One outstanding info frame, acked by matching sequence number.
// RULE_16 - No ack in timer period: poll with RR/RNR, up to retry limit.
// RULE_17 - Info frame ends in ready, repeat, or timeout plus ready.
// RULE_18 - Timer mode bit set before info frames in auto mode.
// RULE_19 - Transparent frames in every mode; completion gives pool-ready.
// RULE_20 - Stop before first pool released: resend once go returns.
// RULE_21 - Stop after first pool released: abort, raise repeat-request.
// RULE_22 - Line-terminal terminal mode puts stop/go on the aux pin.
// RULE_23 - Data goes onto the line only while stop/go reads go; code ignores stop/go while mode bits 3 and 4 are both clear.
// RULE_24 - Opening flag per frame; zero after five ones.
// RULE_25 - CRC-16 over address, control and information octets.
`ifndef HDLCTX_REGS_VH
`define HDLCTX_REGS_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define HDLCTX_A_FIFO 4'h0
`define HDLCTX_A_CMD 4'h1
`define HDLCTX_A_MODE 4'h2
`define HDLCTX_A_ADDR1 4'h3
`define HDLCTX_A_ADDR2 4'h4
`define HDLCTX_A_TIMER 4'h5
`define HDLCTX_A_STATUS 4'h6
`define HDLCTX_A_EVENT 4'h7
`define HDLCTX_A_SEQ 4'h8

// ----------------------------------------
// Command bits
// ----------------------------------------
`define HDLCTX_C_SEND 0
`define HDLCTX_C_INFO 1
`define HDLCTX_C_END 2
`define HDLCTX_C_TRST 3

// ----------------------------------------
// Mode bits and reset values
// ----------------------------------------
`define HDLCTX_M_AUTO 0
`define HDLCTX_M_ADDR2B 1
`define HDLCTX_M_TIMER 2
`define HDLCTX_M_IDLE_LO 3
`define HDLCTX_M_IDLE_HI 4
`define HDLCTX_M_AUX 5
`define HDLCTX_M_CRCMD 6
`define HDLCTX_M_RNR 7
`define HDLCTX_MODE_RST 8'h00
`define HDLCTX_ADDR_RST 8'h00
`define HDLCTX_TIMER_RST 8'h00

// ----------------------------------------
// Sizes and timing
// ----------------------------------------
`define HDLCTX_POOL_BYTES 7'h20
`define HDLCTX_FIFO_BYTES 7'h40
`define HDLCTX_CLK_PS 5000
`define HDLCTX_T1_UNIT_PS 1000000000
`define HDLCTX_FLAG 8'h7e
`define HDLCTX_ABORT 8'h7f
`define HDLCTX_CRC_INIT 16'hffff
`define HDLCTX_CRC_POLY 16'h8408

`endif

// ---- src/hdlctx_top.v ----
// D-channel HDLC transmitter: FIFO, framer, sequence counters, ack supervision.
// Assumes pin inputs for tick and stop/go; receive hints on this clock.
//
// The placing of the registers and the plain strobed port were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "hdlctx_regs.vh"

module hdlctx_top #(
    parameter T1_UNIT_CYC = `HDLCTX_T1_UNIT_PS / `HDLCTX_CLK_PS
) (
    input wire i_clock,
    input wire i_sys_rst,
    input wire [3:0] i_addr,
    input wire [7:0] i_wr_data,
    input wire i_wr,
    input wire i_rd,
    output reg [7:0] o_rd_data,
    input wire i_bit_tick,
    input wire i_stop_go,
    input wire i_rx_ack,
    input wire [2:0] i_rx_nr,
    input wire i_rx_nak,
    input wire i_rx_iframe,
    input wire i_rx_poll,
    output reg o_tx_bit,
    output wire o_tx_active,
    output reg o_aux_test_pin,
    output wire o_fifo_writable_flag,
    output reg o_tx_pool_ready_irq,
    output reg o_tx_underrun_irq,
    output reg o_repeat_request_irq,
    output reg o_ack_timeout_irq
);

// ----------------------------------------
// States and frame kinds
// ----------------------------------------
localparam [3:0] S_IDLE = 4'h0;
localparam [3:0] S_OPEN = 4'h1;
localparam [3:0] S_ADDR1 = 4'h2;
localparam [3:0] S_ADDR2 = 4'h3;
localparam [3:0] S_CTRL = 4'h4;
localparam [3:0] S_DATA = 4'h5;
localparam [3:0] S_CRC1 = 4'h6;
localparam [3:0] S_CRC2 = 4'h7;
localparam [3:0] S_CLOSE = 4'h8;
localparam [3:0] S_ABORT = 4'h9;
localparam [3:0] S_WACK = 4'ha;
localparam [1:0] K_TRANSP = 2'h0;
localparam [1:0] K_INFO = 2'h1;
localparam [1:0] K_SUP = 2'h2;

function [15:0] crc_bit;
    input [15:0] c;
    input b;
    begin
        crc_bit = (c[0] ^ b) ? ((c >> 1) ^ `HDLCTX_CRC_POLY) : (c >> 1);
    end
endfunction

// ----------------------------------------
// Registers
// ----------------------------------------
reg [7:0] mode_ff, addr1_ff, addr2_ff, timer_ff, event_ff;
reg [7:0] fifo_mem [0:63];
reg [6:0] wr_ff, rd_ff, head_ff;
reg [3:0] st_ff;
reg [1:0] kind_ff;
reg resp_ff, released_ff, msg_end_ff, waiting_ff, resp_pend_ff;
reg [7:0] sh_ff;
reg [2:0] bitn_ff, last_ff, ones_ff;
reg stuff_ff, crcen_ff;
reg [15:0] crc_ff;
reg [2:0] vs_ff, vr_ff, tries_ff;
reg [31:0] pre_ff;
reg [4:0] units_ff;
reg tick_s1_ff, tick_s2_ff, tick_s3_ff, sg_s1_ff, sg_s2_ff, sg_prev_ff;

wire [6:0] held = wr_ff - head_ff;
wire [6:0] avail = wr_ff - rd_ff;
wire [6:0] sent = rd_ff - head_ff;
wire idle_on = mode_ff[`HDLCTX_M_IDLE_HI] | mode_ff[`HDLCTX_M_IDLE_LO];
wire stop = sg_s2_ff & idle_on;
wire tick = tick_s2_ff & ~tick_s3_ff;
wire in_frame = (st_ff != S_IDLE) && (st_ff != S_WACK);
wire is_cmd = ~resp_ff;
wire cr_bit = mode_ff[`HDLCTX_M_CRCMD] ^ resp_ff;
wire wr_cmd = i_wr && (i_addr == `HDLCTX_A_CMD);
wire cmd_send = wr_cmd & i_wr_data[`HDLCTX_C_SEND];
wire cmd_info = wr_cmd & i_wr_data[`HDLCTX_C_INFO]
    & mode_ff[`HDLCTX_M_AUTO] & mode_ff[`HDLCTX_M_TIMER]; // see RULE_04
wire cmd_end = wr_cmd & i_wr_data[`HDLCTX_C_END];
wire cmd_trst = wr_cmd & i_wr_data[`HDLCTX_C_TRST];
wire [4:0] t1_units = timer_ff[4:0];
wire [2:0] retry_limit = timer_ff[7:5];

assign o_tx_active = in_frame;
assign o_fifo_writable_flag = (held <= `HDLCTX_POOL_BYTES); // see RULE_02

// ----------------------------------------
// Header octets
// ----------------------------------------
wire [7:0] addr_hi = mode_ff[`HDLCTX_M_ADDR2B] ? {addr1_ff[7:2], cr_bit, addr1_ff[0]} // see RULE_05 see RULE_06
    : (is_cmd ? addr1_ff : addr2_ff); // see RULE_07
wire [7:0] ctrl = (kind_ff == K_SUP)
    ? {vr_ff, 1'b1, 1'b0, mode_ff[`HDLCTX_M_RNR], 2'b01} // see RULE_09 see RULE_16
    : {vr_ff, 1'b0, vs_ff, 1'b0}; // see RULE_08

// ----------------------------------------
// Next byte selection
// ----------------------------------------
reg [3:0] nxt_st;
reg [7:0] nxt_byte;
reg nxt_stuff, nxt_crcen, nxt_pop, ev_under, ev_done;
wire [15:0] crc_now = crcen_ff ? crc_bit(crc_ff, sh_ff[0]) : crc_ff;

always @* begin
    nxt_st = st_ff;
    nxt_byte = `HDLCTX_FLAG;
    nxt_stuff = 1'b1;
    nxt_crcen = 1'b1;
    nxt_pop = 1'b0;
    ev_under = 1'b0;
    ev_done = 1'b0;
    case (st_ff)
        S_OPEN: begin
            if (kind_ff != K_TRANSP) begin
                nxt_st = S_ADDR1;
                nxt_byte = addr_hi;
            end else begin
                nxt_st = S_DATA;
            end
        end
        S_ADDR1: begin
            nxt_st = mode_ff[`HDLCTX_M_ADDR2B] ? S_ADDR2 : S_CTRL;
            nxt_byte = mode_ff[`HDLCTX_M_ADDR2B] ? addr2_ff : ctrl;
        end
        S_ADDR2: begin
            nxt_st = S_CTRL;
            nxt_byte = ctrl;
        end
        S_CTRL: nxt_st = (kind_ff == K_SUP) ? S_CRC1 : S_DATA;
        S_DATA: nxt_st = S_DATA;
        S_CRC1: begin
            nxt_st = S_CRC2;
            nxt_byte = ~crc_now[15:8];
            nxt_crcen = 1'b0;
        end
        S_CRC2: begin
            nxt_st = S_CLOSE;
            nxt_stuff = 1'b0;
            nxt_crcen = 1'b0;
        end
        S_CLOSE: begin
            ev_done = 1'b1;
            nxt_st = (kind_ff == K_INFO || waiting_ff) ? S_WACK : S_IDLE;
        end
        default: nxt_st = S_IDLE;
    endcase
    if (nxt_st == S_DATA) begin
        if (avail != 7'h00) begin
            nxt_byte = fifo_mem[rd_ff[5:0]];
            nxt_pop = 1'b1;
        end else if (msg_end_ff) begin
            nxt_st = S_CRC1; // see RULE_12
            nxt_byte = ~crc_now[7:0];
            nxt_crcen = 1'b0;
        end else begin
            nxt_st = S_ABORT; // see RULE_13
            nxt_byte = `HDLCTX_ABORT;
            nxt_stuff = 1'b0;
            nxt_crcen = 1'b0;
            ev_under = 1'b1;
        end
    end
    if (nxt_st == S_CRC1 && st_ff == S_CTRL) begin
        nxt_byte = ~crc_now[7:0];
        nxt_crcen = 1'b0;
    end
end

// ----------------------------------------
// Register port
// ----------------------------------------
always @(posedge i_clock) begin
    if (i_sys_rst) begin
        mode_ff <= `HDLCTX_MODE_RST;
        addr1_ff <= `HDLCTX_ADDR_RST;
        addr2_ff <= `HDLCTX_ADDR_RST;
        timer_ff <= `HDLCTX_TIMER_RST;
        o_rd_data <= 8'h00;
    end else begin
        if (i_wr && i_addr == `HDLCTX_A_MODE) mode_ff <= i_wr_data;
        if (i_wr && i_addr == `HDLCTX_A_ADDR1) addr1_ff <= i_wr_data;
        if (i_wr && i_addr == `HDLCTX_A_ADDR2) addr2_ff <= i_wr_data;
        if (i_wr && i_addr == `HDLCTX_A_TIMER) timer_ff <= i_wr_data;
        o_rd_data <= 8'h00;
        if (i_rd) begin
            case (i_addr)
                `HDLCTX_A_MODE: o_rd_data <= mode_ff;
                `HDLCTX_A_ADDR1: o_rd_data <= addr1_ff;
                `HDLCTX_A_ADDR2: o_rd_data <= addr2_ff;
                `HDLCTX_A_TIMER: o_rd_data <= timer_ff;
                `HDLCTX_A_STATUS: o_rd_data <= {2'b00, tries_ff, sg_s2_ff, waiting_ff, o_fifo_writable_flag};
                `HDLCTX_A_EVENT: o_rd_data <= event_ff;
                `HDLCTX_A_SEQ: o_rd_data <= {2'b00, vr_ff, vs_ff};
                default: o_rd_data <= 8'h00;
            endcase
        end
    end
end

// ----------------------------------------
// Pin synchronisers and FIFO storage
// ----------------------------------------
always @(posedge i_clock) begin
    if (i_sys_rst) begin
        {tick_s1_ff, tick_s2_ff, tick_s3_ff} <= 3'h0;
        {sg_s1_ff, sg_s2_ff, sg_prev_ff} <= 3'h0;
        o_aux_test_pin <= 1'b0;
    end else begin
        tick_s1_ff <= i_bit_tick;
        tick_s2_ff <= tick_s1_ff;
        tick_s3_ff <= tick_s2_ff;
        sg_s1_ff <= i_stop_go;
        sg_s2_ff <= sg_s1_ff;
        sg_prev_ff <= sg_s2_ff;
        o_aux_test_pin <= mode_ff[`HDLCTX_M_AUX] & sg_s2_ff; // see RULE_22
    end
end

// Storage has no reset; pointers alone define content
always @(posedge i_clock) begin
    if (i_wr && i_addr == `HDLCTX_A_FIFO && held < `HDLCTX_FIFO_BYTES) fifo_mem[wr_ff[5:0]] <= i_wr_data; // see RULE_01
end

// ----------------------------------------
// Framer, sequencing and supervision
// ----------------------------------------
reg pr, du, mr, tout;
always @* begin
    pr = cmd_trst; // see RULE_14
    du = 1'b0;
    mr = 1'b0;
    tout = 1'b0;
    if (in_frame && kind_ff != K_SUP && sent >= `HDLCTX_POOL_BYTES) pr = 1'b1; // see RULE_10
    if (in_frame && tick && !stop && !(stuff_ff && ones_ff == 3'h5) && bitn_ff == last_ff) begin
        du = ev_under;
        if (ev_done && kind_ff == K_TRANSP) pr = 1'b1; // see RULE_19
    end
    if (in_frame && sg_s2_ff && !sg_prev_ff && idle_on && released_ff && kind_ff != K_SUP
        && st_ff != S_ABORT) mr = 1'b1; // see RULE_21
    if (st_ff == S_WACK && !in_frame) begin
        if (i_rx_ack && i_rx_nr == vs_ff + 3'h1) pr = 1'b1; // see RULE_17
        else if (i_rx_nak) mr = 1'b1;
        else if (pre_ff == 32'h0 && units_ff == t1_units && tries_ff == retry_limit) begin
            tout = 1'b1;
            pr = 1'b1;
        end
    end
end

always @(posedge i_clock) begin
    if (i_sys_rst) begin
        event_ff <= 8'h00;
        {o_tx_pool_ready_irq, o_tx_underrun_irq, o_repeat_request_irq, o_ack_timeout_irq} <= 4'h0;
    end else begin
        o_tx_pool_ready_irq <= pr;
        o_tx_underrun_irq <= du;
        o_repeat_request_irq <= mr;
        o_ack_timeout_irq <= tout;
        // Clear on read; set wins
        event_ff <= ((i_rd && i_addr == `HDLCTX_A_EVENT) ? 8'h00 : event_ff) | {4'h0, tout, mr, du, pr};
    end
end

task start_frame;
    input [1:0] k;
    begin
        st_ff <= S_OPEN; // see RULE_24
        kind_ff <= k;
        sh_ff <= `HDLCTX_FLAG;
        bitn_ff <= 3'h0;
        last_ff <= 3'h7;
        stuff_ff <= 1'b0;
        crcen_ff <= 1'b0;
        crc_ff <= `HDLCTX_CRC_INIT;
    end
endtask

task start_abort;
    begin
        st_ff <= S_ABORT;
        sh_ff <= `HDLCTX_ABORT;
        bitn_ff <= 3'h0;
        last_ff <= 3'h6;
        stuff_ff <= 1'b0;
        crcen_ff <= 1'b0;
    end
endtask

always @(posedge i_clock) begin
    if (i_sys_rst) begin
        st_ff <= S_IDLE;
        kind_ff <= K_TRANSP;
        {wr_ff, rd_ff, head_ff} <= 21'h0;
        {resp_ff, released_ff, msg_end_ff, waiting_ff, resp_pend_ff} <= 5'h0;
        sh_ff <= 8'hff;
        {bitn_ff, last_ff, ones_ff} <= 9'h0;
        {stuff_ff, crcen_ff} <= 2'h0;
        crc_ff <= `HDLCTX_CRC_INIT;
        {vs_ff, vr_ff, tries_ff} <= 9'h0;
        pre_ff <= 32'h0;
        units_ff <= 5'h0;
        o_tx_bit <= 1'b1;
    end else begin
        if (i_wr && i_addr == `HDLCTX_A_FIFO && held < `HDLCTX_FIFO_BYTES) wr_ff <= wr_ff + 7'h1;
        if (i_rx_iframe) vr_ff <= vr_ff + 3'h1;
        if (i_rx_poll) resp_pend_ff <= 1'b1;
        if ((cmd_send || cmd_info) && in_frame) msg_end_ff <= msg_end_ff | cmd_end; // see RULE_11
        if (in_frame && kind_ff != K_SUP && sent >= `HDLCTX_POOL_BYTES) begin
            head_ff <= head_ff + `HDLCTX_POOL_BYTES;
            released_ff <= 1'b1;
        end
        if (cmd_trst) begin
            head_ff <= wr_ff;
            rd_ff <= wr_ff;
            waiting_ff <= 1'b0;
            if (in_frame) begin
                start_abort;
            end else begin
                st_ff <= S_IDLE;
            end
        end else if (st_ff == S_IDLE) begin
            o_tx_bit <= 1'b1;
            released_ff <= 1'b0;
            if (cmd_send || cmd_info) begin
                start_frame(cmd_info ? K_INFO : K_TRANSP);
                resp_ff <= 1'b0;
                msg_end_ff <= cmd_end;
                head_ff <= rd_ff;
            end else if (resp_pend_ff && mode_ff[`HDLCTX_M_AUTO]) begin
                start_frame(K_SUP); // see RULE_09
                resp_ff <= 1'b1;
                resp_pend_ff <= 1'b0;
            end
        end else if (st_ff == S_WACK) begin
            o_tx_bit <= 1'b1;
            if (i_rx_ack && i_rx_nr == vs_ff + 3'h1) begin
                vs_ff <= vs_ff + 3'h1; // see RULE_15
                waiting_ff <= 1'b0;
                st_ff <= S_IDLE;
            end else if (i_rx_nak) begin
                waiting_ff <= 1'b0;
                st_ff <= S_IDLE;
            end else if (pre_ff == 32'h0 && units_ff == t1_units) begin
                units_ff <= 5'h0;
                if (tries_ff == retry_limit) begin
                    waiting_ff <= 1'b0;
                    st_ff <= S_IDLE;
                end else begin
                    tries_ff <= tries_ff + 3'h1; // see RULE_16
                    start_frame(K_SUP);
                    resp_ff <= 1'b0;
                end
            end else if (pre_ff == T1_UNIT_CYC - 1) begin
                pre_ff <= 32'h0;
                units_ff <= units_ff + 5'h1;
            end else begin
                pre_ff <= pre_ff + 32'h1;
            end
        end else if (sg_s2_ff && !sg_prev_ff && idle_on && kind_ff != K_SUP && st_ff != S_ABORT) begin
            o_tx_bit <= 1'b1; // see RULE_23
            if (!released_ff) begin
                rd_ff <= head_ff; // see RULE_20
                start_frame(kind_ff);
            end else begin
                start_abort;
            end
        end else if (stop) begin
            o_tx_bit <= 1'b1; // see RULE_23
        end else if (tick) begin
            if (stuff_ff && ones_ff == 3'h5) begin
                o_tx_bit <= 1'b0; // see RULE_24
                ones_ff <= 3'h0;
            end else begin
                o_tx_bit <= sh_ff[0];
                ones_ff <= (sh_ff[0] && stuff_ff) ? ones_ff + 3'h1 : 3'h0;
                if (crcen_ff) crc_ff <= crc_bit(crc_ff, sh_ff[0]); // see RULE_25
                sh_ff <= {1'b1, sh_ff[7:1]};
                if (bitn_ff != last_ff) begin
                    bitn_ff <= bitn_ff + 3'h1;
                end else begin
                    st_ff <= nxt_st;
                    sh_ff <= nxt_byte;
                    bitn_ff <= 3'h0;
                    last_ff <= (nxt_st == S_ABORT) ? 3'h6 : 3'h7;
                    stuff_ff <= nxt_stuff;
                    crcen_ff <= nxt_crcen;
                    if (nxt_pop) rd_ff <= rd_ff + 7'h1;
                    if (ev_done && kind_ff == K_INFO) begin
                        waiting_ff <= 1'b1;
                        tries_ff <= 3'h0;
                        pre_ff <= 32'h0;
                        units_ff <= 5'h0;
                    end
                    if (ev_done && kind_ff != K_SUP) head_ff <= rd_ff;
                    if (nxt_st == S_ABORT || (st_ff == S_ABORT)) head_ff <= rd_ff;
                end
            end
        end
    end
end

endmodule
`default_nettype wire

// ---- dv/hdlctx_chk.sv ----
// Port checker for the HDLC transmitter, bound to the top.
// Assumes offsets 0 fifo, 1 command, 2 mode.
`timescale 1ns/1ps
`default_nettype none
module hdlctx_chk (
    input wire logic i_clock,
    input wire logic i_sys_rst,
    input wire logic [3:0] i_addr,
    input wire logic [7:0] i_wr_data,
    input wire logic i_wr,
    input wire logic i_stop_go,
    input wire logic o_tx_bit,
    input wire logic o_tx_active,
    input wire logic o_aux_test_pin,
    input wire logic o_tx_pool_ready_irq
);
    logic [7:0] mode_ff;
    logic [7:0] stop_ff;
    logic [7:0] idle_ff;
    logic load_ff;
    wire logic cmd = i_wr && i_addr == 4'h1;
    wire logic send_t = cmd && i_wr_data[0] && !i_wr_data[3];
    // ----------------------------------------
    // Shadow state
    // ----------------------------------------
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            mode_ff <= 8'h00;
            stop_ff <= 8'h00;
            idle_ff <= 8'h00;
            load_ff <= 1'b0;
        end else begin
            if (i_wr && i_addr == 4'h2) mode_ff <= i_wr_data;
            stop_ff <= !i_stop_go ? 8'h00 : stop_ff + {7'h00, stop_ff != 8'hff};
            idle_ff <= o_tx_active ? 8'h00 : idle_ff + {7'h00, idle_ff != 8'hff};
            load_ff <= (i_wr && i_addr == 4'h0) || (load_ff && !o_tx_active && !(cmd && i_wr_data[3]));
        end
    end
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (i_sys_rst);
    // Slack for the two-stage sync
    a_stop_quiet: assert property (stop_ff > 8'd5 && mode_ff[4:3] != 2'b00 |-> o_tx_bit)
        else $error("line not idle while stopped");
    a_aux_on: assert property (mode_ff[5] && $past(mode_ff[5]) && stop_ff > 8'd3 |-> o_aux_test_pin)
        else $error("aux pin misses stop");
    a_aux_off: assert property (!mode_ff[5] && !$past(mode_ff[5]) |-> !o_aux_test_pin)
        else $error("aux pin driven outside mode");
    a_idle_ones: assert property (idle_ff > 8'd40 |-> o_tx_bit)
        else $error("idle line not high");
    a_send_starts: assert property (send_t && load_ff && stop_ff == 8'h00 |=> o_tx_active)
        else $error("send command did not start");
    a_info_refused: assert property (cmd && i_wr_data[1:0] == 2'b10 && !i_wr_data[3] && !mode_ff[0]
        && !o_tx_active |=> !o_tx_active [*8])
        else $error("info frame sent outside auto");
    a_reset_ready: assert property (cmd && i_wr_data[3] |-> ##[1:40] o_tx_pool_ready_irq)
        else $error("no ready after reset command");
    a_ready_pulse: assert property (o_tx_pool_ready_irq |=> !o_tx_pool_ready_irq)
        else $error("ready not a pulse");
endmodule
bind hdlctx_top hdlctx_chk chk (
    .i_clock(i_clock),
    .i_sys_rst(i_sys_rst),
    .i_addr(i_addr),
    .i_wr_data(i_wr_data),
    .i_wr(i_wr),
    .i_stop_go(i_stop_go),
    .o_tx_bit(o_tx_bit),
    .o_tx_active(o_tx_active),
    .o_aux_test_pin(o_aux_test_pin),
    .o_tx_pool_ready_irq(o_tx_pool_ready_irq)
);
`default_nettype wire

// ---- dv/hdlctx_peer.sv ----
// Far-end peer: free-running bit clock and frame decoder.
// Assumes the block shifts on the tick rising edge, LSB first.
`timescale 1ns/1ps
`default_nettype none
module hdlctx_peer (
    input wire logic i_clock,
    input wire logic i_tx_bit,
    output logic o_bit_tick,
    output logic o_byte_v,
    output logic [7:0] o_byte,
    output logic o_end_v,
    output logic o_crc_ok
);
    logic [3:0] div_ff = 4'h0;
    logic [2:0] ones_ff = 3'h7;
    logic in_ff = 1'b0;
    logic [7:0] sh_ff;
    logic [2:0] nb_ff;
    logic [1:0] cnt_ff;
    logic [7:0] p0_ff;
    logic [7:0] p1_ff;
    logic [15:0] crc_ff;
    wire logic [7:0] nxt_sh = {i_tx_bit, sh_ff[7:1]};
    assign o_bit_tick = div_ff[3];
    function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
        logic [15:0] x;
        x = c ^ {8'h00, d};
        for (int i = 0; i < 8; i++) x = x[0] ? (x >> 1) ^ 16'h8408 : x >> 1;
        return x;
    endfunction
    // ----------------------------------------
    // Mid-bit sample; two check bytes held back
    // ----------------------------------------
    always @(posedge i_clock) begin
        div_ff <= div_ff + 4'h1;
        o_byte_v <= 1'b0;
        o_end_v <= 1'b0;
        if (div_ff == 4'hf) begin
            ones_ff <= !i_tx_bit ? 3'h0 : (ones_ff == 3'h7 ? 3'h7 : ones_ff + 3'h1);
            if (i_tx_bit && ones_ff == 3'h6) begin
                in_ff <= 1'b0;
            end else if (!i_tx_bit && ones_ff == 3'h6) begin
                o_end_v <= in_ff && nb_ff == 3'h7 && cnt_ff == 2'h2;
                o_crc_ok <= crc_ff == 16'hf0b8;
                in_ff <= 1'b1;
                nb_ff <= 3'h0;
                cnt_ff <= 2'h0;
                crc_ff <= 16'hffff;
            end else if (in_ff && (i_tx_bit || ones_ff != 3'h5)) begin
                sh_ff <= nxt_sh;
                nb_ff <= nb_ff + 3'h1;
                if (nb_ff == 3'h7) begin
                    crc_ff <= crc_byte(crc_ff, nxt_sh);
                    p0_ff <= p1_ff;
                    p1_ff <= nxt_sh;
                    o_byte <= p0_ff;
                    o_byte_v <= cnt_ff == 2'h2;
                    if (cnt_ff != 2'h2) cnt_ff <= cnt_ff + 2'h1;
                end
            end
        end
    end
endmodule
`default_nettype wire

// ---- dv/test_hdlc_dchannel_transmitter.sv ----
// Self-checking bench for the HDLC transmitter.
// Assumes the peer model makes the bit clock and decodes frames.
`timescale 1ns/1ps
`default_nettype none
module test_hdlc_dchannel_transmitter;
    logic i_clock = 1'b0;
    logic i_sys_rst = 1'b1;
    logic [3:0] addr = 4'h0;
    logic [7:0] wd = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic rd_d = 1'b0;
    logic stop = 1'b0;
    logic ack = 1'b0;
    logic nak = 1'b0;
    logic rxi = 1'b0;
    wire [7:0] rdd;
    wire [7:0] pb;
    wire tick, txb, act, pb_v, pe_v, crc_ok;
    int failures = 0;
    int checks = 0;
    logic [7:0] rq[$];
    logic [7:0] fq[$];
    hdlctx_top #(.T1_UNIT_CYC(10)) uut (
        .i_clock(i_clock),
        .i_sys_rst(i_sys_rst),
        .i_addr(addr),
        .i_wr_data(wd),
        .i_wr(wr),
        .i_rd(rd),
        .o_rd_data(rdd),
        .i_bit_tick(tick),
        .i_stop_go(stop),
        .i_rx_ack(ack),
        .i_rx_nr(3'h1),
        .i_rx_nak(nak),
        .i_rx_iframe(rxi),
        .i_rx_poll(1'b0),
        .o_tx_bit(txb),
        .o_tx_active(act),
        .o_aux_test_pin(),
        .o_fifo_writable_flag(),
        .o_tx_pool_ready_irq(),
        .o_tx_underrun_irq(),
        .o_repeat_request_irq(),
        .o_ack_timeout_irq()
    );
    hdlctx_peer peer (
        .i_clock(i_clock),
        .i_tx_bit(txb),
        .o_bit_tick(tick),
        .o_byte_v(pb_v),
        .o_byte(pb),
        .o_end_v(pe_v),
        .o_crc_ok(crc_ok)
    );
    initial begin
        forever #2.5 i_clock = ~i_clock;
    end
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wreg(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_clock);
        addr <= a;
        wd <= d;
        wr <= 1'b1;
        @(posedge i_clock);
        wr <= 1'b0;
    endtask
    task automatic rreg(input logic [3:0] a, input logic [7:0] e);
        @(posedge i_clock);
        addr <= a;
        rd <= 1'b1;
        rq.push_back(e);
        @(posedge i_clock);
        rd <= 1'b0;
    endtask
    // 64 quiet cycles outlast the retry gap
    task automatic idle();
        int n = 0;
        int q = 0;
        while (q < 64 && n < 9000) begin
            @(posedge i_clock);
            n++;
            q = act ? 0 : q + 1;
        end
        if (n >= 9000) failures++;
    endtask
    task automatic results();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // ----------------------------------------
    // Monitor
    // ----------------------------------------
    always @(posedge i_clock) begin
        rd_d <= rd;
        if (rd_d) chk(rdd, rq.pop_front());
        if (pb_v) chk(pb, fq.pop_front());
        if (pe_v) chk({7'h00, crc_ok}, 8'h01);
    end
    initial begin
        repeat (40000) @(posedge i_clock);
        failures++;
        results();
    end
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        logic [7:0] b;
        int r;
        r = $urandom(7);
        repeat (4) @(posedge i_clock);
        i_sys_rst <= 1'b0;
        rreg(4'h2, 8'h00);
        rreg(4'h6, 8'h01);
        rreg(4'hf, 8'h00);
        rreg(4'h8, 8'h00);
        wreg(4'h2, 8'h38);
        repeat (3) begin
            b = 8'($urandom);
            wreg(4'h0, b);
            fq.push_back(b);
        end
        wreg(4'h1, 8'h05);
        repeat (200) @(posedge i_clock);
        stop <= 1'b1;
        repeat (300) @(posedge i_clock);
        rreg(4'h6, 8'h05);
        stop <= 1'b0;
        idle();
        rreg(4'h7, 8'h01);
        wreg(4'h2, 8'h00);
        wreg(4'h0, 8'h5a);
        wreg(4'h1, 8'h01);
        idle();
        rreg(4'h7, 8'h02);
        wreg(4'h0, 8'h11);
        wreg(4'h1, 8'h06);
        repeat (20) @(posedge i_clock);
        chk({7'h00, act}, 8'h00);
        wreg(4'h1, 8'h01);
        repeat (30) @(posedge i_clock);
        wreg(4'h1, 8'h08);
        idle();
        rreg(4'h7, 8'h01);
        wreg(4'h3, 8'h30);
        wreg(4'h4, 8'h05);
        wreg(4'h5, 8'h3f);
        wreg(4'h2, 8'h05);
        fq = {fq, 8'h30, 8'h00, 8'h6c};
        wreg(4'h0, 8'h6c);
        wreg(4'h1, 8'h06);
        idle();
        @(posedge i_clock) ack <= 1'b1;
        @(posedge i_clock) ack <= 1'b0;
        rreg(4'h7, 8'h01);
        @(posedge i_clock) rxi <= 1'b1;
        @(posedge i_clock) rxi <= 1'b0;
        rreg(4'h8, 8'h09);
        wreg(4'h2, 8'h47);
        fq = {fq, 8'h32, 8'h05, 8'h22, 8'h6c};
        wreg(4'h0, 8'h6c);
        wreg(4'h1, 8'h06);
        idle();
        @(posedge i_clock) nak <= 1'b1;
        @(posedge i_clock) nak <= 1'b0;
        rreg(4'h7, 8'h04);
        wreg(4'h5, 8'h21);
        fq = {fq, 8'h32, 8'h05, 8'h22, 8'h6c, 8'h32, 8'h05, 8'h31};
        wreg(4'h0, 8'h6c);
        wreg(4'h1, 8'h06);
        idle();
        rreg(4'h7, 8'h09);
        repeat (4) @(posedge i_clock);
        chk(8'(fq.size()), 8'h00);
        results();
    end
endmodule
`default_nettype wire
